// file: src/cpe_params.svh
// Register indices, field positions, reset values and bus constants for the channel-pair block.
`ifndef CPE_PARAMS_SVH
`define CPE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CPE_IDX_W          12
`define CPE_IDX_PAIR_EN    12'h209
`define CPE_IDX_SYNC_HDR   12'h20f
`define CPE_IDX_LINK_CTRL  12'h200
`define CPE_IDX_LINK_STAT  12'h201

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CPE_BIT_LOWER_EN   0
`define CPE_BIT_UPPER_EN   1
`define CPE_BIT_SINGLE_EN  2
`define CPE_BIT_LINK_EN    0
`define CPE_BIT_CAL_EN     1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CPE_RST_PAIR_EN    8'h03
`define CPE_RST_SYNC_HDR   8'h00
`define CPE_RST_CTRL       1'b0

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define CPE_RESP_OKAY      2'h0
`define CPE_RESP_SLVERR    2'h2

`endif

// file: src/cpe_pkg.sv
// Types shared by the channel-pair enable block.
package cpe_pkg;

	// Link settings handed to the framer.
	typedef struct packed {
		logic [3:0] chan_active;
		logic [3:0] lanes;
		logic [2:0] convs;
		logic       tail_pad;
		logic       cd_in_ab_slots;
	} cpe_link_cfg_t;

	// Software controls for the link and calibration.
	typedef struct packed {
		logic [7:0] sync_hdr;
		logic       cal_enable;
		logic       link_enable;
	} cpe_ctrl_t;

	// Write channel states of the bus slave.
	typedef enum logic [2:0] {
		CPE_WR_IDLE = 3'b001,
		CPE_WR_HOLD = 3'b010,
		CPE_WR_RESP = 3'b100
	} cpe_wr_state_t;

endpackage

// file: src/cpe_link_cfg.sv
// Derives the framer's lane, converter and channel settings from the channel-enable byte.
`timescale 1ns/1ps
`include "cpe_params.svh"

module cpe_link_cfg #(
	parameter int FULL_LANES = 8,
	parameter int FULL_CONVS = 4
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic [7:0]            i_pair_en,
	output cpe_pkg::cpe_link_cfg_t     o_cfg
);
	import cpe_pkg::*;

	localparam logic [3:0] LANES_FULL = 4'(FULL_LANES);
	localparam logic [3:0] LANES_HALF = 4'((FULL_LANES + 1) / 2);
	localparam logic [2:0] CONVS_FULL = 3'(FULL_CONVS);
	localparam logic [2:0] CONVS_HALF = 3'(FULL_CONVS / 2);
	localparam logic       LANES_ODD  = LANES_FULL[0];

	wire           lower_on = i_pair_en[`CPE_BIT_LOWER_EN];
	wire           upper_on = i_pair_en[`CPE_BIT_UPPER_EN];
	wire           single   = i_pair_en[`CPE_BIT_SINGLE_EN];
	wire           pair_off = !lower_on || !upper_on || single;
	cpe_link_cfg_t next_cfg;

	// ------------------------------------------------------------------------
	// Effective settings
	// ------------------------------------------------------------------------
	// Channel order in chan_active is D, C, B, A from the top bit down.
	assign next_cfg.chan_active    = {upper_on && !single, upper_on && !single,
		lower_on && !single, lower_on};
	assign next_cfg.lanes          = pair_off ? LANES_HALF : LANES_FULL;
	assign next_cfg.convs          = pair_off ? CONVS_HALF : CONVS_FULL;
	assign next_cfg.tail_pad       = pair_off && LANES_ODD;
	assign next_cfg.cd_in_ab_slots = !lower_on && upper_on && !single;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cfg <= '0;
		end else begin
			o_cfg <= next_cfg;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	// The settings register still holds its reset value one cycle after release.
	logic rst_seen;

	always_ff @(posedge i_clk) begin
		rst_seen <= i_rst;
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst || rst_seen);

	a_single_only_a: assert property (
		i_pair_en[2] && i_pair_en[0] |=> o_cfg.chan_active == 4'b0001)
		else $error("single mode left a channel other than A running");
	a_upper_pair_on: assert property (
		!i_pair_en[2] |=> o_cfg.chan_active[3:2] == {2{$past(i_pair_en[1])}})
		else $error("channels C and D do not follow their enable");
	a_lower_pair_on: assert property (
		!i_pair_en[2] |=> o_cfg.chan_active[1:0] == {2{$past(i_pair_en[0])}})
		else $error("channels A and B do not follow their enable");
	a_lanes_halved: assert property (
		(i_pair_en[1:0] != 2'b11) |=> o_cfg.lanes == LANES_HALF && o_cfg.convs == CONVS_HALF)
		else $error("lane or converter count not halved with a pair off");
	a_lanes_full: assert property (
		(i_pair_en[2:0] == 3'b011) |=> o_cfg.lanes == LANES_FULL && !o_cfg.tail_pad)
		else $error("full configuration not restored with both pairs on");
	a_tail_pad: assert property (
		(i_pair_en[1:0] != 2'b11) |=> o_cfg.tail_pad == LANES_ODD)
		else $error("tail padding wrong for the lane count");
	a_cd_in_ab: assert property (
		(i_pair_en[2:0] == 3'b010) |=> o_cfg.cd_in_ab_slots && o_cfg.chan_active == 4'b1100)
		else $error("C and D samples not moved into the A and B slots");

endmodule

// file: src/cpe_ctrl.sv
// AXI4-Lite register bank for channel-pair enables, link control and link settings.
// ----------------------------------------------------------------------------
// Overview of operation
// - With single mode set, channels B, C and D are off and channel A runs only if bit 0 is set.
// - Bit 1 turns channels C and D on or off, resets to 1 and is needed for dual use.
// - Bit 0 turns channels A and B on or off and resets to 1.
// - With a pair off, the link uses half the lanes rounded up and half the converters.
// - With a pair off and an odd full lane count, the highest lane gets tail padding.
// - With the lower pair off, C and D samples take the A and B frame positions.
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "cpe_params.svh"

module cpe_ctrl #(
	parameter int AW         = 14,
	parameter int FULL_LANES = 8,
	parameter int FULL_CONVS = 4
) (
	input  wire logic                  I_MCLK,
	input  wire logic                  I_SRST,
	input  wire logic [AW-1:0]         I_AWADDR,
	input  wire logic                  I_AWVALID,
	output logic                       O_AWREADY,
	input  wire logic [31:0]           I_WDATA,
	input  wire logic [3:0]            I_WSTRB,
	input  wire logic                  I_WVALID,
	output logic                       O_WREADY,
	output logic [1:0]                 O_BRESP,
	output logic                       O_BVALID,
	input  wire logic                  I_BREADY,
	input  wire logic [AW-1:0]         I_ARADDR,
	input  wire logic                  I_ARVALID,
	output logic                       O_ARREADY,
	output logic [31:0]                O_RDATA,
	output logic [1:0]                 O_RRESP,
	output logic                       O_RVALID,
	input  wire logic                  I_RREADY,
	output logic [7:0]                 O_PAIR_EN,
	output cpe_pkg::cpe_ctrl_t         O_CTRL,
	output cpe_pkg::cpe_link_cfg_t     O_LINK_CFG
);
	import cpe_pkg::*;

	localparam int IW = `CPE_IDX_W;

	// ------------------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------------------
	cpe_wr_state_t wr_state;
	cpe_wr_state_t next_wr_state;
	logic          aw_held;
	logic          w_held;
	logic [IW-1:0] wr_idx;
	logic [7:0]    wr_byte;
	logic          wr_lane0;

	wire aw_take  = I_AWVALID && O_AWREADY;
	wire w_take   = I_WVALID && O_WREADY;
	wire aw_have  = aw_held || aw_take;
	wire w_have   = w_held || w_take;
	wire wr_fire  = (wr_state == CPE_WR_HOLD) && aw_held && w_held;
	wire b_done   = O_BVALID && I_BREADY;

	wire wr_hit_ch   = wr_idx == `CPE_IDX_PAIR_EN;
	wire wr_hit_sh   = wr_idx == `CPE_IDX_SYNC_HDR;
	wire wr_hit_ctl  = wr_idx == `CPE_IDX_LINK_CTRL;
	wire wr_hit_st   = wr_idx == `CPE_IDX_LINK_STAT;
	wire wr_mapped   = wr_hit_ch || wr_hit_sh || wr_hit_ctl || wr_hit_st;
	wire wr_store    = wr_fire && wr_lane0;

	always_comb begin
		next_wr_state = wr_state;
		unique case (wr_state)
			CPE_WR_IDLE: begin
				if (aw_take || w_take) begin
					next_wr_state = CPE_WR_HOLD;
				end
			end
			CPE_WR_HOLD: begin
				if (wr_fire) begin
					next_wr_state = CPE_WR_RESP;
				end
			end
			CPE_WR_RESP: begin
				if (b_done) begin
					next_wr_state = CPE_WR_IDLE;
				end
			end
			default: begin
				next_wr_state = CPE_WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			wr_state <= CPE_WR_IDLE;
		end else begin
			wr_state <= next_wr_state;
		end
	end

	// Address and data may arrive in either order; each ready drops once its item is held.
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			O_AWREADY <= 1'b1;
			O_WREADY  <= 1'b1;
		end else begin
			aw_held   <= aw_have && !b_done;
			w_held    <= w_have && !b_done;
			O_AWREADY <= !aw_have || b_done;
			O_WREADY  <= !w_have || b_done;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			wr_idx   <= '0;
			wr_byte  <= '0;
			wr_lane0 <= 1'b0;
		end else begin
			if (aw_take) begin
				wr_idx <= I_AWADDR[AW-1:2];
			end
			if (w_take) begin
				wr_byte  <= I_WDATA[7:0];
				wr_lane0 <= I_WSTRB[0];
			end
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			O_BVALID <= 1'b0;
			O_BRESP  <= `CPE_RESP_OKAY;
		end else if (wr_fire) begin
			O_BVALID <= 1'b1;
			O_BRESP  <= wr_mapped ? `CPE_RESP_OKAY : `CPE_RESP_SLVERR;
		end else if (b_done) begin
			O_BVALID <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	// Reserved bits 7:3 are stored as written so that a read returns them.
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			O_PAIR_EN <= `CPE_RST_PAIR_EN;
		end else if (wr_store && wr_hit_ch) begin
			O_PAIR_EN <= wr_byte;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			O_CTRL.sync_hdr    <= `CPE_RST_SYNC_HDR;
			O_CTRL.cal_enable  <= `CPE_RST_CTRL;
			O_CTRL.link_enable <= `CPE_RST_CTRL;
		end else begin
			if (wr_store && wr_hit_sh) begin
				O_CTRL.sync_hdr <= wr_byte;
			end
			if (wr_store && wr_hit_ctl) begin
				O_CTRL.cal_enable  <= wr_byte[`CPE_BIT_CAL_EN];
				O_CTRL.link_enable <= wr_byte[`CPE_BIT_LINK_EN];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Link settings
	// ------------------------------------------------------------------------
	cpe_link_cfg #(
		.FULL_LANES (FULL_LANES),
		.FULL_CONVS (FULL_CONVS)
	) u_link_cfg (
		.i_clk     (I_MCLK),
		.i_rst     (I_SRST),
		.i_pair_en (O_PAIR_EN),
		.o_cfg     (O_LINK_CFG)
	);

	// ------------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------------
	wire [IW-1:0] rd_idx     = I_ARADDR[AW-1:2];
	wire          ar_take    = I_ARVALID && O_ARREADY;
	wire          r_done     = O_RVALID && I_RREADY;
	wire          rd_hit_ch  = rd_idx == `CPE_IDX_PAIR_EN;
	wire          rd_hit_sh  = rd_idx == `CPE_IDX_SYNC_HDR;
	wire          rd_hit_ctl = rd_idx == `CPE_IDX_LINK_CTRL;
	wire          rd_hit_st  = rd_idx == `CPE_IDX_LINK_STAT;
	wire          rd_mapped  = rd_hit_ch || rd_hit_sh || rd_hit_ctl || rd_hit_st;
	wire [31:0]   rd_word    =
		rd_hit_ch  ? {24'h000000, O_PAIR_EN} :
		rd_hit_sh  ? {24'h000000, O_CTRL.sync_hdr} :
		rd_hit_ctl ? {30'h00000000, O_CTRL.cal_enable, O_CTRL.link_enable} :
		rd_hit_st  ? {19'h00000, O_LINK_CFG} :
		32'h00000000;

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			O_ARREADY <= 1'b1;
			O_RVALID  <= 1'b0;
			O_RDATA   <= '0;
			O_RRESP   <= `CPE_RESP_OKAY;
		end else if (ar_take) begin
			O_ARREADY <= 1'b0;
			O_RVALID  <= 1'b1;
			O_RDATA   <= rd_word;
			O_RRESP   <= rd_mapped ? `CPE_RESP_OKAY : `CPE_RESP_SLVERR;
		end else if (r_done) begin
			O_ARREADY <= 1'b1;
			O_RVALID  <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	a_pairs_reset_on: assert property (@(posedge I_MCLK)
		$past(I_SRST) && !I_SRST |-> O_PAIR_EN == 8'h03 && !O_CTRL.link_enable)
		else $error("pair enables not on after reset");
	a_ch_write_lands: assert property (@(posedge I_MCLK) disable iff (I_SRST)
		wr_store && wr_hit_ch |=> O_PAIR_EN == $past(wr_byte) && O_BVALID)
		else $error("channel-enable write did not land with its response");
	a_cfg_follows_en: assert property (@(posedge I_MCLK) disable iff (I_SRST)
		wr_store && wr_hit_ch && wr_byte[1:0] == 2'b01 ##1 !(wr_store && wr_hit_ch)
		|=> O_LINK_CFG.lanes == 4'((FULL_LANES + 1) / 2))
		else $error("lane count not halved two cycles after a pair was disabled");
	a_write_answered: assert property (@(posedge I_MCLK) disable iff (I_SRST)
		aw_take ##0 w_take |-> ##[1:2] O_BVALID)
		else $error("write response late");
	a_read_answered: assert property (@(posedge I_MCLK) disable iff (I_SRST)
		ar_take |=> O_RVALID && !O_ARREADY)
		else $error("read data not presented one cycle after the address");

endmodule

// file: testbench/test_channel_pair_enable_ctrl.sv
// Self-checking bench for the channel-pair enable register bank.
`timescale 1ns/1ps
`include "cpe_params.svh"

module test_channel_pair_enable_ctrl;
	import cpe_pkg::*;
	localparam int          FL     = 7;
	localparam int          FC     = 4;
	localparam logic [13:0] A_CH   = {`CPE_IDX_PAIR_EN, 2'b00};
	localparam logic [13:0] A_SH   = {`CPE_IDX_SYNC_HDR, 2'b00};
	localparam logic [13:0] A_LINK = {`CPE_IDX_LINK_CTRL, 2'b00};
	localparam logic [13:0] A_STAT = {`CPE_IDX_LINK_STAT, 2'b00};
	localparam logic [13:0] A_BAD  = 14'h0ffc;

	logic           mclk = 1'b0;
	logic           srst = 1'b1;
	logic [13:0]    awaddr = '0;
	logic           awvalid = 1'b0;
	logic [31:0]    wdata = '0;
	logic [3:0]     wstrb = '0;
	logic           wvalid = 1'b0;
	logic           bready = 1'b0;
	logic [13:0]    araddr = '0;
	logic           arvalid = 1'b0;
	logic           rready = 1'b0;
	logic           awready, wready, bvalid, arready, rvalid;
	logic [1:0]     bresp, rresp;
	logic [31:0]    rdata;
	logic [7:0]     pair_en;
	cpe_ctrl_t      ctrl;
	cpe_link_cfg_t  cfg;
	int             num_errors = 0;
	int             check_count = 0;

	always #2 mclk = ~mclk;

	cpe_ctrl #(.AW(14), .FULL_LANES(FL), .FULL_CONVS(FC)) u_cpe_ctrl (
		.I_MCLK(mclk), .I_SRST(srst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
		.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
		.I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
		.O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_PAIR_EN(pair_en),
		.O_CTRL(ctrl), .O_LINK_CFG(cfg)
	);

	// ------------------------------------------------------------------------
	// Reporting and bus tasks
	// ------------------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic hang();
		num_errors++;
		$display("unexpected bus answer expected within 50 cycles seen none");
		complete_run();
	endtask

	task automatic bus_write(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		@(posedge mclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) hang();
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic bus_read(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge mclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) hang();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Stops the link, stores a new channel byte and checks the echo and the stored byte.
	task automatic set_pairs(input logic [7:0] ch);
		logic [1:0]  r;
		logic [31:0] d;
		bus_write(A_LINK, 32'h0, 4'hf, r);
		check("link ctrl resp", 32'h0, {30'h0, r});
		bus_write(A_CH, {24'h0, ch}, 4'hf, r);
		check("pair_en write resp", 32'h0, {30'h0, r});
		repeat (2) @(posedge mclk);
		check("pair_en port", {24'h0, ch}, {24'h0, pair_en});
		check("link off port", 32'h0, {30'h0, ctrl.cal_enable, ctrl.link_enable});
		bus_read(A_CH, d, r);
		check("pair_en readback", {24'h0, ch}, d);
		check("pair_en read resp", 32'h0, {30'h0, r});
	endtask

	task automatic sc_reset();
		logic [31:0] d;
		logic [1:0]  r;
		check("pair_en reset", 32'h3, {24'h0, pair_en});
		check("chan_active full", 32'hf, {28'h0, cfg.chan_active});
		check("lanes full", FL, {28'h0, cfg.lanes});
		check("convs full", FC, {29'h0, cfg.convs});
		check("tail full", 32'h0, {31'h0, cfg.tail_pad});
		bus_read(A_CH, d, r);
		check("pair_en reset read", 32'h3, d);
	endtask

	task automatic sc_upper_off();
		set_pairs(8'h01);
		check("chan_active cd off", 32'h3, {28'h0, cfg.chan_active});
		check("lanes halved", 32'h4, {28'h0, cfg.lanes});
		check("convs halved", 32'h2, {29'h0, cfg.convs});
		check("tail pad odd", 32'h1, {31'h0, cfg.tail_pad});
		check("no swap", 32'h0, {31'h0, cfg.cd_in_ab_slots});
	endtask

	task automatic sc_lower_off();
		set_pairs(8'h02);
		check("chan_active ab off", 32'hc, {28'h0, cfg.chan_active});
		check("lanes ab off", 32'h4, {28'h0, cfg.lanes});
		check("cd in ab slots", 32'h1, {31'h0, cfg.cd_in_ab_slots});
		check("tail ab off", 32'h1, {31'h0, cfg.tail_pad});
	endtask

	task automatic sc_single();
		set_pairs(8'h05);
		check("chan_active single", 32'h1, {28'h0, cfg.chan_active});
		check("convs single", 32'h2, {29'h0, cfg.convs});
		check("single no swap", 32'h0, {31'h0, cfg.cd_in_ab_slots});
	endtask

	task automatic sc_bus_edges();
		logic [31:0] d;
		logic [1:0]  r;
		bus_write(A_BAD, 32'h0, 4'hf, r);
		check("unmapped write resp", 32'h2, {30'h0, r});
		bus_read(A_BAD, d, r);
		check("unmapped read resp", 32'h2, {30'h0, r});
		check("unmapped read data", 32'h0, d);
		bus_write(A_SH, 32'h2, 4'hf, r);
		check("sync hdr write resp", 32'h0, {30'h0, r});
		bus_read(A_SH, d, r);
		check("sync hdr read", 32'h2, d);
		check("sync hdr port", 32'h2, {24'h0, ctrl.sync_hdr});
		bus_write(A_CH, 32'h3, 4'he, r);
		repeat (2) @(posedge mclk);
		check("masked lane kept", 32'h5, {24'h0, pair_en});
		bus_write(A_STAT, 32'hffff, 4'hf, r);
		check("status write resp", 32'h0, {30'h0, r});
		bus_read(A_STAT, d, r);
		check("status read", {19'h0, 13'h028a}, d);
	endtask

	task automatic sc_restore();
		set_pairs(8'h03);
		check("lanes restored", FL, {28'h0, cfg.lanes});
		check("tail restored", 32'h0, {31'h0, cfg.tail_pad});
		check("chan restored", 32'hf, {28'h0, cfg.chan_active});
	endtask

	// Sets link control, drops a pair, then resets in mid-run and checks pair_en, ctrl and the lanes and active channels of the link settings.
	task automatic sc_midrun_reset();
		logic [31:0] d;
		logic [1:0]  r;
		bus_write(A_LINK, 32'h3, 4'hf, r);
		check("link ctrl write resp", 32'h0, {30'h0, r});
		bus_read(A_LINK, d, r);
		check("link ctrl read", 32'h3, d);
		check("link ctrl port", 32'h3, {30'h0, ctrl.cal_enable, ctrl.link_enable});
		set_pairs(8'h01);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		check("pair_en after reset", 32'h3, {24'h0, pair_en});
		check("ctrl after reset", 32'h0, {22'h0, ctrl});
		check("lanes after reset", FL, {28'h0, cfg.lanes});
		check("chan after reset", 32'hf, {28'h0, cfg.chan_active});
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		@(posedge mclk);
		sc_reset();
		sc_upper_off();
		sc_lower_off();
		sc_single();
		sc_bus_edges();
		sc_restore();
		sc_midrun_reset();
		complete_run();
	end
endmodule
